// [verilog/tcr_pkg.sv]
// Shared constants and types for the temperature readout link
package tcr_pkg;

  // ---------------------------------------------------------------
  // Link command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_CONVERT   = 8'h44;
  localparam logic [7:0] CMD_WRITE_SP  = 8'h4e;
  localparam logic [7:0] CMD_READ_SP   = 8'hbe;
  localparam logic [7:0] CMD_READ_SLOT = 8'h00; // One read slot, bit 0 answers

  // ---------------------------------------------------------------
  // Scratchpad layout and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0]  SP_TEMP_LSB    = 3'h0;
  localparam logic [2:0]  SP_TEMP_MSB    = 3'h1;
  localparam logic [2:0]  SP_HIGH_TRIG   = 3'h2;
  localparam logic [2:0]  SP_LOW_TRIG    = 3'h3;
  localparam logic [2:0]  SP_CONFIG      = 3'h4;
  localparam logic [15:0] TEMP_POR       = 16'h0550;
  localparam logic [15:0] TEMP_FULL_MASK = 16'hffff;
  localparam logic [7:0]  HIGH_TRIG_INIT = 8'h7f;
  localparam logic [7:0]  LOW_TRIG_INIT  = 8'h80;
  localparam int          SAMPLE_W       = 12;
  localparam int          SIGN_EXT_W     = 4;
  localparam int          ALARM_MSB      = 11;
  localparam int          ALARM_LSB      = 4;
  localparam int          CFG_RES_LSB    = 5;
  localparam int          CFG_RES_MSB    = 6;
  localparam logic [1:0]  RES_9          = 2'h0;
  localparam logic [1:0]  RES_12         = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int         CLK_FREQ_KHZ    = 20000;
  localparam int         CONV_TIME_12_MS = 750;
  localparam int         CONV_CYCLES_12  = CONV_TIME_12_MS * CLK_FREQ_KHZ;
  localparam int         CONV_CNT_W      = 24;
  localparam logic [7:0] RSP_TIMEOUT     = 8'h08;

  // ---------------------------------------------------------------
  // Controller registers on AXI4-Lite
  // ---------------------------------------------------------------
  localparam int          AXI_ADDR_W   = 12;
  localparam logic [11:0] REG_CMD      = 12'h000;
  localparam logic [11:0] REG_ROM_LO   = 12'h004;
  localparam logic [11:0] REG_ROM_HI   = 12'h008;
  localparam logic [11:0] REG_STATUS   = 12'h00c;
  localparam logic [11:0] REG_MODE     = 12'h010;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int          CMD_ADDR_LSB = 8;
  localparam int          CMD_DATA_LSB = 16;
  localparam int          ST_BUSY      = 0;
  localparam int          ST_DONE      = 1;
  localparam int          ST_NOANS     = 2;
  localparam int          ST_PULLUP    = 3;
  localparam int          ST_DATA_LSB  = 8;

  typedef enum logic [0:0] {DEV_IDLE, DEV_CONVERT} tcr_dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_PULLUP} tcr_host_state_t;

endpackage

// [verilog/tcr_link_if.sv]
// Link between the bus master and the temperature sensor
`timescale 1ns/1ps

interface tcr_link_if;
  logic        reqValid;
  logic [7:0]  reqCmd;
  logic [63:0] reqRom;
  logic [2:0]  reqAddr;
  logic [7:0]  reqData;
  logic        strongPullup;
  logic        rspValid;
  logic [7:0]  rspData;

  modport master (
    output reqValid, reqCmd, reqRom, reqAddr, reqData, strongPullup,
    input  rspValid, rspData
  );

  modport sensor (
    input  reqValid, reqCmd, reqRom, reqAddr, reqData, strongPullup,
    output rspValid, rspData
  );
endinterface

// [verilog/tcr_sensor_dev.sv]
// Sensor end: conversion control, result register, alarm and scratchpad
`timescale 1ns/1ps

module tcr_sensor_dev
  import tcr_pkg::*;
#(
  parameter logic [63:0] DEV_ROM     = 64'h5a0f_3c96_0000_01a5, // Arbitrary identity value
  parameter int          CONV_CYCLES = CONV_CYCLES_12
) (
  input  wire logic          core_clk,
  input  wire logic          srst,
  input  wire logic          nvInit,
  input  wire logic          localSupplyPin,
  input  wire logic [3:0]    locationAddressPins,
  input  wire logic [11:0]   sensorSample,
  tcr_link_if.sensor         link,
  output logic      [15:0]   tempResult,
  output logic               alarmFlag,
  output logic               converting
);

  tcr_dev_state_t        state_r,    state_nxt;
  logic [CONV_CNT_W-1:0] convCnt_r,  convCnt_nxt;
  logic [1:0]            convRes_r,  convRes_nxt;
  logic [15:0]           temp_r,     temp_nxt;
  logic                  alarm_r,    alarm_nxt;
  logic                  busy_r,     busy_nxt;
  logic                  rspValid_r, rspValid_nxt;
  logic [7:0]            rspData_r,  rspData_nxt;
  logic [7:0]            highTrig_r, highTrig_nxt;
  logic [7:0]            lowTrig_r,  lowTrig_nxt;
  logic [1:0]            res_r,      res_nxt;
  logic [3:0]            locMeta_r;
  logic [3:0]            locSync_r;
  logic                  supMeta_r;
  logic                  supSync_r;

  logic                  romHit;
  logic [1:0]            resShift;
  logic [CONV_CNT_W-1:0] convLimit;
  logic [15:0]           newTemp;
  logic signed [7:0]     tCmp;
  logic [7:0]            cfgByte;

  // ---------------------------------------------------------------
  // Outputs and link answer
  // ---------------------------------------------------------------
  assign tempResult   = temp_r;
  assign alarmFlag    = alarm_r;
  assign converting   = busy_r;
  assign link.rspValid = rspValid_r;
  assign link.rspData  = rspData_r;

  // Configuration byte: resolution in bits 6:5, location address in 3:0
  assign cfgByte = {1'b0, res_r, 1'b0, locSync_r};

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    convCnt_nxt  = convCnt_r;
    convRes_nxt  = convRes_r;
    temp_nxt     = temp_r;
    alarm_nxt    = alarm_r;
    busy_nxt     = busy_r;
    highTrig_nxt = highTrig_r;
    lowTrig_nxt  = lowTrig_r;
    res_nxt      = res_r;
    rspData_nxt  = 8'h00;

    // Only a request carrying our own code is taken or answered
    romHit       = link.reqValid && (link.reqRom == DEV_ROM);
    rspValid_nxt = romHit;

    // Each step down in resolution halves the conversion time
    resShift  = RES_12 - convRes_r;
    convLimit = CONV_CNT_W'(CONV_CYCLES) >> resShift;
    if (convLimit == '0) begin
      convLimit = CONV_CNT_W'(1);
    end

    // Sign-extend the sample; bits below the resolution read as zero
    newTemp = {{SIGN_EXT_W{sensorSample[SAMPLE_W-1]}}, sensorSample};
    newTemp = newTemp & (TEMP_FULL_MASK << resShift);
    tCmp    = $signed(newTemp[ALARM_MSB:ALARM_LSB]);

    // Conversion sequencer
    case (state_r)
      DEV_IDLE: begin
        if (romHit && (link.reqCmd == CMD_CONVERT)) begin
          state_nxt   = DEV_CONVERT;
          convCnt_nxt = '0;
          convRes_nxt = res_r;
          busy_nxt    = 1'b1;
        end
      end
      DEV_CONVERT: begin
        // A further convert request while busy is answered but ignored
        convCnt_nxt = convCnt_r + CONV_CNT_W'(1);
        if (convCnt_r == convLimit - CONV_CNT_W'(1)) begin
          state_nxt = DEV_IDLE;
          busy_nxt  = 1'b0;
          temp_nxt  = newTemp;
          alarm_nxt = (tCmp <= $signed(lowTrig_r)) ||
                      (tCmp >= $signed(highTrig_r));
        end
      end
      default: begin
        state_nxt = DEV_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase

    // Scratchpad writes; new triggers are used by the next compare
    if (romHit && (link.reqCmd == CMD_WRITE_SP)) begin
      if (link.reqAddr == SP_HIGH_TRIG) begin
        highTrig_nxt = link.reqData;
      end else if (link.reqAddr == SP_LOW_TRIG) begin
        lowTrig_nxt = link.reqData;
      end else if (link.reqAddr == SP_CONFIG) begin
        res_nxt = link.reqData[CFG_RES_MSB:CFG_RES_LSB];
      end
    end

    // Scratchpad reads; the result bytes are read-only
    if (romHit && (link.reqCmd == CMD_READ_SP)) begin
      if (link.reqAddr == SP_TEMP_LSB) begin
        rspData_nxt = temp_r[7:0];
      end else if (link.reqAddr == SP_TEMP_MSB) begin
        rspData_nxt = temp_r[15:8];
      end else if (link.reqAddr == SP_HIGH_TRIG) begin
        rspData_nxt = highTrig_r;
      end else if (link.reqAddr == SP_LOW_TRIG) begin
        rspData_nxt = lowTrig_r;
      end else if (link.reqAddr == SP_CONFIG) begin
        rspData_nxt = cfgByte;
      end else begin
        rspData_nxt = 8'h00;
      end
    end

    // Completion polling works only with a local supply
    if (romHit && (link.reqCmd == CMD_READ_SLOT)) begin
      rspData_nxt = {7'h00, supSync_r && !busy_r};
    end
  end

  // ---------------------------------------------------------------
  // Working registers, loaded with their reset values by reset
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r    <= DEV_IDLE;
      convCnt_r  <= '0;
      convRes_r  <= RES_12;
      temp_r     <= TEMP_POR;
      alarm_r    <= 1'b0;
      busy_r     <= 1'b0;
      rspValid_r <= 1'b0;
      rspData_r  <= 8'h00;
      locMeta_r  <= 4'h0;
      locSync_r  <= 4'h0;
      supMeta_r  <= 1'b0;
      supSync_r  <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      convCnt_r  <= convCnt_nxt;
      convRes_r  <= convRes_nxt;
      temp_r     <= temp_nxt;
      alarm_r    <= alarm_nxt;
      busy_r     <= busy_nxt;
      rspValid_r <= rspValid_nxt;
      rspData_r  <= rspData_nxt;
      // Straps and supply sense are pins, so two stages first
      locMeta_r  <= locationAddressPins;
      locSync_r  <= locMeta_r;
      supMeta_r  <= localSupplyPin;
      supSync_r  <= supMeta_r;
    end
  end

  // ---------------------------------------------------------------
  // Stored settings: only the factory init loads their initial values
  // ---------------------------------------------------------------
  // Logic reset leaves these alone, which stands in for the
  // nonvolatile copy; they are written through on every write.
  always_ff @(posedge core_clk) begin
    if (nvInit) begin
      highTrig_r <= HIGH_TRIG_INIT;
      lowTrig_r  <= LOW_TRIG_INIT;
      res_r      <= RES_12;
    end else begin
      highTrig_r <= highTrig_nxt;
      lowTrig_r  <= lowTrig_nxt;
      res_r      <= res_nxt;
    end
  end

endmodule

// [verilog/tcr_bus_master.sv]
// Master end: AXI4-Lite command registers driving the sensor link
`timescale 1ns/1ps

module tcr_bus_master
  import tcr_pkg::*;
#(
  parameter int PULLUP_CYCLES = CONV_CYCLES_12
) (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [AXI_ADDR_W-1:0] awaddr,
  input  wire logic                  wvalid,
  output logic                       wready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  output logic                       bvalid,
  input  wire logic                  bready,
  output logic      [1:0]            bresp,
  input  wire logic                  arvalid,
  output logic                       arready,
  input  wire logic [AXI_ADDR_W-1:0] araddr,
  output logic                       rvalid,
  input  wire logic                  rready,
  output logic      [31:0]           rdata,
  output logic      [1:0]            rresp,
  tcr_link_if.master                 link
);

  tcr_host_state_t       state_r,   state_nxt;
  logic [CONV_CNT_W-1:0] cnt_r,     cnt_nxt;
  logic                  awHave_r,  awHave_nxt;
  logic [AXI_ADDR_W-1:0] awAddr_r,  awAddr_nxt;
  logic                  wHave_r,   wHave_nxt;
  logic [31:0]           wData_r,   wData_nxt;
  logic [3:0]            wStrb_r,   wStrb_nxt;
  logic                  bvalid_r,  bvalid_nxt;
  logic [1:0]            bresp_r,   bresp_nxt;
  logic                  rvalid_r,  rvalid_nxt;
  logic [31:0]           rdata_r,   rdata_nxt;
  logic [1:0]            rresp_r,   rresp_nxt;
  logic [31:0]           romLo_r,   romLo_nxt;
  logic [31:0]           romHi_r,   romHi_nxt;
  logic                  mode_r,    mode_nxt;
  logic                  done_r,    done_nxt;
  logic                  noAns_r,   noAns_nxt;
  logic [7:0]            rspByte_r, rspByte_nxt;
  logic                  req_r,     req_nxt;
  logic [7:0]            cmd_r,     cmd_nxt;
  logic [2:0]            addr_r,    addr_nxt;
  logic [7:0]            data_r,    data_nxt;
  logic                  pullup_r,  pullup_nxt;
  logic                  awReady_r, awReady_nxt;
  logic                  wReady_r,  wReady_nxt;
  logic                  arReady_r, arReady_nxt;

  logic [31:0] wMask;
  logic [31:0] status;

  // ---------------------------------------------------------------
  // Port drive, all from registers
  // ---------------------------------------------------------------
  assign awready           = awReady_r;
  assign wready            = wReady_r;
  assign arready           = arReady_r;
  assign bvalid            = bvalid_r;
  assign bresp             = bresp_r;
  assign rvalid            = rvalid_r;
  assign rdata             = rdata_r;
  assign rresp             = rresp_r;
  assign link.reqValid     = req_r;
  assign link.reqCmd       = cmd_r;
  assign link.reqRom       = {romHi_r, romLo_r};
  assign link.reqAddr      = addr_r;
  assign link.reqData      = data_r;
  assign link.strongPullup = pullup_r;

  // Byte-lane mask and status word
  assign wMask  = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
  assign status = {16'h0000, rspByte_r, 4'h0, pullup_r, noAns_r, done_r,
                   (state_r != H_IDLE)};

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    awHave_nxt = awHave_r;
    awAddr_nxt = awAddr_r;
    wHave_nxt = wHave_r;
    wData_nxt = wData_r;
    wStrb_nxt = wStrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    romLo_nxt = romLo_r;
    romHi_nxt = romHi_r;
    mode_nxt = mode_r;
    done_nxt = done_r;
    noAns_nxt = noAns_r;
    rspByte_nxt = rspByte_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    pullup_nxt = pullup_r;
    req_nxt = 1'b0;

    // Address and data are taken independently, in either order
    if (awvalid && !awHave_r) begin
      awHave_nxt = 1'b1;
      awAddr_nxt = awaddr;
    end
    if (wvalid && !wHave_r) begin
      wHave_nxt = 1'b1;
      wData_nxt = wdata;
      wStrb_nxt = wstrb;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt = 1'b0;
    end

    // Perform the write once both halves are held
    if (awHave_r && wHave_r && !bvalid_r) begin
      awHave_nxt = 1'b0;
      wHave_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      if (awAddr_r == REG_CMD) begin
        // Launch refused while busy, or a poll when bus powered
        if ((state_r != H_IDLE) || (mode_r && (wData_r[7:0] == CMD_READ_SLOT))) begin
          bresp_nxt = RESP_SLVERR;
        end else begin
          req_nxt   = 1'b1;
          cmd_nxt   = wData_r[7:0];
          addr_nxt  = wData_r[CMD_ADDR_LSB+2:CMD_ADDR_LSB];
          data_nxt  = wData_r[CMD_DATA_LSB+7:CMD_DATA_LSB];
          done_nxt  = 1'b0;
          noAns_nxt = 1'b0;
          cnt_nxt   = '0;
          state_nxt = H_WAIT;
        end
      end else if (awAddr_r == REG_ROM_LO) begin
        romLo_nxt = (romLo_r & ~wMask) | (wData_r & wMask);
      end else if (awAddr_r == REG_ROM_HI) begin
        romHi_nxt = (romHi_r & ~wMask) | (wData_r & wMask);
      end else if (awAddr_r == REG_MODE) begin
        if (wStrb_r[0]) begin
          mode_nxt = wData_r[0];
        end
      end else if (awAddr_r != REG_STATUS) begin
        bresp_nxt = RESP_SLVERR;
      end
    end

    // Read channel: data one cycle after the address is taken
    if (rvalid_r && rready) begin
      rvalid_nxt = 1'b0;
    end else if (arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OKAY;
      if (araddr == REG_CMD) begin
        rdata_nxt = {8'h00, data_r, 5'h00, addr_r, cmd_r};
      end else if (araddr == REG_ROM_LO) begin
        rdata_nxt = romLo_r;
      end else if (araddr == REG_ROM_HI) begin
        rdata_nxt = romHi_r;
      end else if (araddr == REG_STATUS) begin
        rdata_nxt = status;
      end else if (araddr == REG_MODE) begin
        rdata_nxt = {31'h0, mode_r};
      end else begin
        rdata_nxt = 32'h0;
        rresp_nxt = RESP_SLVERR;
      end
    end

    // Link sequencer
    case (state_r)
      H_IDLE: begin
      end
      H_WAIT: begin
        cnt_nxt = cnt_r + CONV_CNT_W'(1);
        if (link.rspValid) begin
          rspByte_nxt = link.rspData;
          cnt_nxt     = '0;
          if (mode_r && (cmd_r == CMD_CONVERT)) begin
            pullup_nxt = 1'b1;
            state_nxt  = H_PULLUP;
          end else begin
            done_nxt  = 1'b1;
            state_nxt = H_IDLE;
          end
        end else if (cnt_r == CONV_CNT_W'(RSP_TIMEOUT)) begin
          // No device with this code answered
          noAns_nxt = 1'b1;
          state_nxt = H_IDLE;
        end
      end
      H_PULLUP: begin
        // Full twelve-bit time: the master cannot see the resolution
        cnt_nxt = cnt_r + CONV_CNT_W'(1);
        if (cnt_r >= CONV_CNT_W'(PULLUP_CYCLES) - CONV_CNT_W'(1)) begin
          pullup_nxt = 1'b0;
          done_nxt   = 1'b1;
          state_nxt  = H_IDLE;
        end
      end
      default: begin
        state_nxt = H_IDLE;
      end
    endcase

    // Ready flags kept in flops so no port is driven through a gate
    awReady_nxt = !awHave_nxt;
    wReady_nxt  = !wHave_nxt;
    arReady_nxt = !rvalid_nxt;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r <= H_IDLE;
      cnt_r <= '0;
      awHave_r <= 1'b0;
      awAddr_r <= '0;
      wHave_r <= 1'b0;
      wData_r <= 32'h0;
      wStrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
      romLo_r <= 32'h0;
      romHi_r <= 32'h0;
      mode_r <= 1'b0;
      done_r <= 1'b0;
      noAns_r <= 1'b0;
      rspByte_r <= 8'h00;
      req_r <= 1'b0;
      cmd_r <= 8'h00;
      addr_r <= 3'h0;
      data_r <= 8'h00;
      pullup_r <= 1'b0;
      awReady_r <= 1'b1;
      wReady_r <= 1'b1;
      arReady_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      awHave_r <= awHave_nxt;
      awAddr_r <= awAddr_nxt;
      wHave_r <= wHave_nxt;
      wData_r <= wData_nxt;
      wStrb_r <= wStrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      romLo_r <= romLo_nxt;
      romHi_r <= romHi_nxt;
      mode_r <= mode_nxt;
      done_r <= done_nxt;
      noAns_r <= noAns_nxt;
      rspByte_r <= rspByte_nxt;
      req_r <= req_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      pullup_r <= pullup_nxt;
      awReady_r <= awReady_nxt;
      wReady_r <= wReady_nxt;
      arReady_r <= arReady_nxt;
    end
  end

endmodule

// [tb/tcr_link_sva.sv]
// Protocol checker for the sensor link between the two ends
`timescale 1ns/1ps
module tcr_link_sva
  import tcr_pkg::*;
#(
  parameter logic [63:0] DEV_ROM = 64'h0
) (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        reqValid,
  input wire logic [7:0]  reqCmd,
  input wire logic [63:0] reqRom,
  input wire logic [2:0]  reqAddr,
  input wire logic [7:0]  reqData,
  input wire logic        strongPullup,
  input wire logic        rspValid,
  input wire logic [7:0]  rspData
);
  // ----------
  // Link rules
  // ----------
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  ans_after_req_a: assert property (reqValid && reqRom == DEV_ROM |=> rspValid)
    else $error("matching request not answered");
  no_stray_ans_a: assert property (rspValid |-> $past(reqValid) && $past(reqRom) == DEV_ROM)
    else $error("answer without a matching request");
  ans_pulse_a: assert property (rspValid |=> !rspValid)
    else $error("answer longer than one cycle");
  reserved_zero_a: assert property (reqValid && reqRom == DEV_ROM && reqCmd == CMD_READ_SP
    && reqAddr > 3'h4 |=> rspData == 8'h00) else $error("reserved byte not zero");
  pullup_cause_a: assert property ($rose(strongPullup) |-> $past(reqCmd) == CMD_CONVERT)
    else $error("pullup without convert");
  pullup_hold_a: assert property ($rose(strongPullup) |-> strongPullup [*8])
    else $error("pullup dropped early");
  quiet_pullup_a: assert property (strongPullup |-> !reqValid)
    else $error("traffic during pullup");
  pullup_end_a: assert property (strongPullup |-> ##[1:70] !strongPullup)
    else $error("pullup never released");
endmodule

// [tb/tb_temperature_conversion_result.sv]
// Self-checking bench for the temperature readout link
`timescale 1ns/1ps
module tb_temperature_conversion_result;
  import tcr_pkg::*;
  localparam logic [63:0] ROM = 64'h1234_5678_9abc_def0; // Arbitrary identity value
  logic        core_clk = 1'b0;
  logic        srst     = 1'b1;
  logic        nvInit   = 1'b1;
  logic        supply   = 1'b1;
  logic [3:0]  locPins  = 4'ha;
  logic [11:0] sample   = 12'h000;
  logic [11:0] awaddr   = 12'h000;
  logic [11:0] araddr   = 12'h000;
  logic [31:0] wdata    = 32'h0;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, alarmFlag, converting;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, st;
  logic [15:0] tempResult;
  int          errCount   = 0;
  int          checkCount = 0;
  tcr_link_if link ();
  tcr_sensor_dev #(.DEV_ROM(ROM), .CONV_CYCLES(64)) i_tcr_sensor_dev (.core_clk(core_clk),
    .srst(srst), .nvInit(nvInit), .localSupplyPin(supply), .locationAddressPins(locPins),
    .sensorSample(sample), .link(link), .tempResult(tempResult), .alarmFlag(alarmFlag),
    .converting(converting));
  tcr_bus_master #(.PULLUP_CYCLES(64)) i_tcr_bus_master (.core_clk(core_clk), .srst(srst),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .link(link));
  tcr_link_sva #(.DEV_ROM(ROM)) i_tcr_link_sva (.core_clk(core_clk), .srst(srst),
    .reqValid(link.reqValid), .reqCmd(link.reqCmd), .reqRom(link.reqRom),
    .reqAddr(link.reqAddr), .reqData(link.reqData), .strongPullup(link.strongPullup),
    .rspValid(link.rspValid), .rspData(link.rspData));
  // Free-running 20 MHz clock
  always #25 core_clk = ~core_clk;
  // ----------
  // Shared tasks
  // ----------
  task automatic endSim;
    if (errCount == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checkCount++;
    if (got !== exp) begin
      errCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang;
    errCount++;
    $display("wrong value at %0t: wait ran out", $time);
    endSim;
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axiWr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) hang;
    rs = bresp;
    bready <= 1'b0;
  endtask
  task automatic axiRd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    @(posedge core_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) hang;
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // Launch one link request, then poll status until the master is idle
  task automatic cmd(input logic [7:0] c, input logic [2:0] a, input logic [7:0] d,
                     input logic [1:0] er);
    int n;
    axiWr(REG_CMD, {8'h00, d, 5'h00, a, c}, r);
    chk(16'(r), 16'(er));
    for (n = 0; n < 200; n++) begin
      axiRd(REG_STATUS, st, r);
      if (st[ST_BUSY] === 1'b0) break;
    end
    if (n == 200) hang;
  endtask
  // ----------
  // Scenarios
  // ----------
  // Conversion at one resolution; the slow one also polls mid-run
  task automatic conv(input logic [1:0] res, input logic [11:0] s);
    logic [15:0] old;
    logic [15:0] exp;
    int          n;
    old = tempResult;
    exp = {{4{s[11]}}, s} & (16'hffff << (3 - res));
    sample <= s;
    cmd(CMD_WRITE_SP, SP_CONFIG, {1'b0, res, 5'h00}, RESP_OKAY);
    cmd(CMD_CONVERT, 3'h0, 8'h00, RESP_OKAY);
    if (res == RES_12) begin
      cmd(CMD_READ_SLOT, 3'h0, 8'h00, RESP_OKAY);
      chk(16'(st[8]), 16'h0);
      chk(tempResult, old);
    end
    for (n = 0; n < 100 && converting !== 1'b0; n++) @(posedge core_clk);
    if (n == 100) hang;
    cmd(CMD_READ_SLOT, 3'h0, 8'h00, RESP_OKAY);
    chk(16'(st[8]), 16'h1);
    chk(tempResult, exp);
    cmd(CMD_READ_SP, SP_TEMP_LSB, 8'h00, RESP_OKAY);
    chk(16'(st[15:8]), 16'(exp[7:0]));
  endtask
  // Trigger pair against a result whose bits 11 to 4 are f5
  task automatic alarm(input logic [7:0] h, input logic [7:0] l, input logic e);
    cmd(CMD_WRITE_SP, SP_HIGH_TRIG, h, RESP_OKAY);
    cmd(CMD_WRITE_SP, SP_LOW_TRIG, l, RESP_OKAY);
    conv(RES_12, 12'hf5e);
    chk(16'(alarmFlag), 16'(e));
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    {srst, nvInit} <= 2'b00;
    @(posedge core_clk);
    chk(tempResult, TEMP_POR);
    axiWr(REG_ROM_LO, ROM[31:0], r);
    axiWr(REG_ROM_HI, ROM[63:32], r);
    cmd(CMD_READ_SP, SP_CONFIG, 8'h00, RESP_OKAY);
    chk(16'(st[15:8]), {9'h000, RES_12, 1'b0, 4'ha});
    cmd(CMD_READ_SP, SP_TEMP_MSB, 8'h00, RESP_OKAY);
    chk(16'(st[15:8]), 16'h0005);
    cmd(CMD_READ_SP, 3'h6, 8'h00, RESP_OKAY);
    chk(16'(st[15:8]), 16'h0000);
    conv(RES_9, 12'h7d7);
    conv(2'h1, 12'hf5e);
    conv(2'h2, 12'h191);
    conv(RES_12, 12'hc90);
    alarm(8'h7f, 8'hf5, 1'b1);
    alarm(8'h7f, 8'hf4, 1'b0);
    alarm(8'hf5, 8'h80, 1'b1);
    alarm(8'hf6, 8'h80, 1'b0);
    // Bus-powered target: polling refused, pullup carries the conversion
    supply <= 1'b0;
    axiWr(REG_MODE, 32'h1, r);
    cmd(CMD_READ_SLOT, 3'h0, 8'h00, RESP_SLVERR);
    cmd(CMD_CONVERT, 3'h0, 8'h00, RESP_OKAY);
    chk(16'(st[ST_DONE]), 16'h1);
    axiWr(REG_MODE, 32'h0, r);
    supply <= 1'b1;
    axiRd(12'h7f0, st, r);
    chk(16'(r), 16'(RESP_SLVERR));
    chk(st[15:0], 16'h0000);
    // Logic reset while no conversion runs keeps stored settings; straps are moved meanwhile
    locPins <= 4'h3;
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    chk(tempResult, TEMP_POR);
    axiWr(REG_ROM_LO, ROM[31:0], r);
    axiWr(REG_ROM_HI, ROM[63:32], r);
    cmd(CMD_READ_SP, SP_HIGH_TRIG, 8'h00, RESP_OKAY);
    chk(16'(st[15:8]), 16'h00f6);
    cmd(CMD_READ_SP, SP_CONFIG, 8'h00, RESP_OKAY);
    chk(16'(st[15:8]), {9'h000, RES_12, 1'b0, 4'h3});
    axiWr(REG_ROM_LO, ~ROM[31:0], r);
    cmd(CMD_READ_SP, SP_HIGH_TRIG, 8'h00, RESP_OKAY);
    chk(16'(st[ST_NOANS]), 16'h1);
    endSim;
  end
endmodule
